// >>> hdl/pcs_sequencer.sv
`timescale 1ns/100ps
// How it works
// - an 11-bit instruction pointer addresses 2048 words of 14 bits
// - any reset loads address zero and fetching starts there
// - trap instruction pushes return address and jumps to address one
// - a taken interrupt pushes return address and jumps to address eight
// - plain instructions take one cycle, flow changes take two
// - six-deep return stack: calls and interrupts push, returns pop
// - long call and long jump carry a full 11-bit target, ignoring pages
// - while the reset pin is low the sequencer stays in reset
// - each instruction is one 14-bit word
// - the counter advances by one each cycle unless overridden
// - low-byte write: bits 9,10 from status bits 5,6, bit 8 cleared
module pcs_sequencer
  import pcs_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DEPTH = STACK_DEPTH
)(
  // clock and resets
  input wire logic CLK,
  input wire logic RST,
  input wire logic SHARED_RESET_PIN_N,
  // program memory
  output logic [AW-1:0] INSTR_ADDR,
  input wire logic [WORD_W-1:0] INSTR_WORD,
  output logic [WORD_W-1:0] INSTR_OUT,
  output logic INSTR_VALID,
  // decoded flow request for the instruction in execute
  input wire pcs_op_e FLOW_OP,
  input wire logic [AW-1:0] FLOW_TARGET,
  input wire logic [7:0] LOW_BYTE_DATA,
  input wire logic [7:0] STATUS_REG,
  input wire logic IRQ_TAKE,
  // state view
  output logic [AW-1:0] INSTRUCTION_POINTER,
  output logic [2:0] STACK_LEVEL
);

  // timing of one flow change:
  //   edge 0: the executing op redirects the pointer and may push or pop
  //   slot 1: the word fetched before edge 0 is discarded (flush slot)
  //   edge 1: the word at the new address enters the fetch register
  //   slot 2: that word executes, the pointer already one beyond it

  // reset and flow state
  logic rst_all;
  logic [AW-1:0] pc_q, pc_d;
  logic flush_q, flush_d;
  // return stack
  logic [AW-1:0] stack_q [DEPTH];
  logic [2:0] sp_q;
  logic [2:0] level_q;
  logic push, pop;
  logic [AW-1:0] push_val;
  // precomputed targets
  logic [AW-1:0] low_wr_target;
  logic [AW-1:0] ret_target;

  // fixed vectors widened to the pointer width
  localparam logic [AW-1:0] VEC_RESET = AW'(RESET_VEC);
  localparam logic [AW-1:0] VEC_TRAP = AW'(TRAP_VEC);
  localparam logic [AW-1:0] VEC_IRQ = AW'(IRQ_VEC);

  // either reset source holds the sequencer
  assign rst_all = RST | ~SHARED_RESET_PIN_N;

  // wrap a stack index around the depth
  function automatic logic [2:0] wrap_inc(input logic [2:0] v);
    if (v == 3'(DEPTH - 1))
      wrap_inc = 3'h0;
    else
      wrap_inc = v + 3'h1;
  endfunction

  // step a stack index back, wrapping below zero
  function automatic logic [2:0] wrap_dec(input logic [2:0] v);
    if (v == 3'h0)
      wrap_dec = 3'(DEPTH - 1);
    else
      wrap_dec = v - 3'h1;
  endfunction

  // low-byte write: page bits from status, bit 8 cleared
  assign low_wr_target = AW'({STATUS_REG[PAGE_HIGH_BIT], STATUS_REG[PAGE_LOW_BIT], 1'b0, LOW_BYTE_DATA});

  // a return takes the newest entry, just below the stack pointer
  assign ret_target = stack_q[wrap_dec(sp_q)];

  // next-address selection; an instruction in the flush slot is discarded
  // an interrupt wins over the executing op; its flow op is not carried out
  always_comb
  begin
    pc_d = pc_q + 1'b1;
    flush_d = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_q;
    if (IRQ_TAKE)
    begin
      pc_d = VEC_IRQ;
      push = 1'b1;
      // in a flush slot the pointer still names the word not yet executed,
      // so the pointer itself is the right place to come back to
      push_val = pc_q;
      flush_d = 1'b1;
    end
    // ops are decoded only outside the flush slot
    else if (!flush_q)
    begin
      case (FLOW_OP)
        PCS_OP_JUMP:
        begin
          pc_d = FLOW_TARGET;
          flush_d = 1'b1;
        end
        PCS_OP_CALL:
        begin
          pc_d = FLOW_TARGET;
          push = 1'b1;
          flush_d = 1'b1;
        end
        PCS_OP_RET:
        begin
          pc_d = ret_target;
          pop = 1'b1;
          flush_d = 1'b1;
        end
        PCS_OP_TRAP:
        begin
          pc_d = VEC_TRAP;
          push = 1'b1;
          flush_d = 1'b1;
        end
        PCS_OP_LOW_WR:
        begin
          pc_d = low_wr_target;
          flush_d = 1'b1;
        end
        // skip: no redirect, but the next word is discarded
        PCS_OP_SKIP:
          flush_d = 1'b1;
        default:
          flush_d = 1'b0;
      endcase
    end
  end

  // instruction pointer
  always_ff @(posedge CLK)
  begin
    if (rst_all)
      pc_q <= VEC_RESET;
    else
      pc_q <= pc_d;
  end

  // flush slot marker
  // reset leaves one, so the word latched during reset is never executed
  always_ff @(posedge CLK)
  begin
    if (rst_all)
      flush_q <= 1'b1;
    else
      flush_q <= flush_d;
  end

  // circular stack pointer, oldest entry overwritten on overflow
  // the count saturates at the depth, so a seventh push keeps it at six
  always_ff @(posedge CLK)
  begin
    if (rst_all)
    begin
      sp_q <= 3'h0;
      level_q <= 3'h0;
    end
    else if (push)
    begin
      sp_q <= wrap_inc(sp_q);
      if (level_q != 3'(DEPTH))
        level_q <= level_q + 3'h1;
    end
    else if (pop)
    begin
      sp_q <= wrap_dec(sp_q);
      if (level_q != 3'h0)
        level_q <= level_q - 3'h1;
    end
  end

  // stack storage
  // entries need no reset; a pop of an empty stack reads stale data
  always_ff @(posedge CLK)
  begin
    if (push)
      stack_q[sp_q] <= push_val;
  end

  // fetched word register; one word per instruction
  // registered so the decoder sees a word that is stable for the whole cycle
  always_ff @(posedge CLK)
  begin
    if (rst_all)
      INSTR_OUT <= '0;
    else
      INSTR_OUT <= INSTR_WORD;
  end

  // execute flag, low for the word that follows a flow change
  always_ff @(posedge CLK)
  begin
    if (rst_all)
      INSTR_VALID <= 1'b0;
    else
      INSTR_VALID <= ~flush_d;
  end

  // the fetch address and the state view are the registers themselves
  assign INSTR_ADDR = pc_q;
  assign INSTRUCTION_POINTER = pc_q;
  assign STACK_LEVEL = level_q;

endmodule

// >>> hdl/pcs_pkg.sv
package pcs_pkg;
  // program memory geometry
  localparam int ADDR_W = 11;
  localparam int WORD_W = 14;
  localparam int STACK_DEPTH = 6;
  // fixed vectors
  localparam logic [10:0] RESET_VEC = 11'h000;
  localparam logic [10:0] TRAP_VEC = 11'h001;
  localparam logic [10:0] IRQ_VEC = 11'h008;
  // status bit positions feeding the upper counter bits
  localparam int PAGE_LOW_BIT = 5;
  localparam int PAGE_HIGH_BIT = 6;
  // flow operations reported by the instruction decoder
  typedef enum logic [2:0] {
    PCS_OP_NEXT,
    PCS_OP_JUMP,
    PCS_OP_CALL,
    PCS_OP_RET,
    PCS_OP_TRAP,
    PCS_OP_LOW_WR,
    PCS_OP_SKIP
  } pcs_op_e;
endpackage

// >>> test/pcs_mem.sv
`timescale 1ns/100ps
module pcs_mem (
  // fetch port
  input wire logic [10:0] addr,
  output logic [13:0] word
);
  // one word per address, pattern follows the address
  assign word = {3'h5, addr};
endmodule

// >>> test/pcs_props.sv
`timescale 1ns/100ps
module pcs_props
  import pcs_pkg::*;
(
  // clock and resets
  input wire logic CLK,
  input wire logic RST,
  input wire logic SHARED_RESET_PIN_N,
  // flow request
  input wire pcs_op_e FLOW_OP,
  input wire logic [10:0] FLOW_TARGET,
  input wire logic IRQ_TAKE,
  input wire logic [7:0] LOW_BYTE_DATA,
  input wire logic [7:0] STATUS_REG,
  // program memory
  input wire logic [13:0] INSTR_WORD,
  input wire logic [13:0] INSTR_OUT,
  // state
  input wire logic INSTR_VALID,
  input wire logic [10:0] INSTRUCTION_POINTER,
  input wire logic [2:0] STACK_LEVEL
);
  // shorthands for the properties
  wire rs = RST || !SHARED_RESET_PIN_N;
  wire ex = INSTR_VALID && !IRQ_TAKE;
  wire nx = !IRQ_TAKE && (!INSTR_VALID || FLOW_OP == PCS_OP_NEXT);
  wire psh = IRQ_TAKE || ex && FLOW_OP inside {PCS_OP_CALL, PCS_OP_TRAP};
  wire [10:0] p = INSTRUCTION_POINTER;
  wire [2:0] lv = STACK_LEVEL;
  wire [1:0] pg = {STATUS_REG[PAGE_HIGH_BIT], STATUS_REG[PAGE_LOW_BIT]};
  default clocking @(posedge CLK); endclocking
  default disable iff (rs);
  a_reset_vec: assert property (disable iff (0) rs |=> p == 0 && lv == 0) else $error("r");
  a_next_step: assert property (nx |=> p == 11'($past(p) + 1)) else $error("n");
  a_flow_flush: assert property (ex && FLOW_OP != PCS_OP_NEXT |=> !INSTR_VALID) else $error("f");
  a_jump_full: assert property (ex && FLOW_OP inside {PCS_OP_JUMP, PCS_OP_CALL} |=> p == $past(FLOW_TARGET))
    else $error("j");
  a_trap_vec: assert property (ex && FLOW_OP == PCS_OP_TRAP |=> p == TRAP_VEC) else $error("t");
  a_irq_vec: assert property (IRQ_TAKE |=> p == IRQ_VEC) else $error("i");
  a_push_level: assert property (psh |=> lv == $past(lv) + ($past(lv) < STACK_DEPTH)) else $error("u");
  a_pop_level: assert property (ex && FLOW_OP == PCS_OP_RET && lv != 0 |=> lv == $past(lv) - 1) else $error("o");
  a_low_write: assert property (ex && FLOW_OP == PCS_OP_LOW_WR |=>
    p == {$past(pg), 1'b0, $past(LOW_BYTE_DATA)}) else $error("low write target");
  a_skip_step: assert property (ex && FLOW_OP == PCS_OP_SKIP |=>
    p == 11'($past(p) + 1) && !INSTR_VALID) else $error("skip step");
  a_level_bound: assert property (lv <= STACK_DEPTH) else $error("level above depth");
  a_word_fetch: assert property (!rs |=> INSTR_OUT == $past(INSTR_WORD)) else $error("fetch word");
endmodule
bind pcs_sequencer pcs_props pcs_props_i (.*);

// >>> test/program_counter_sequencer_bench.sv
`timescale 1ns/100ps
module program_counter_sequencer_bench;
  import pcs_pkg::*;
  logic clk = 0, rst = 1, pin_n = 1, irq = 0;
  pcs_op_e op = PCS_OP_NEXT;
  logic [10:0] tgt = 0, a, ip, r, q[$];
  logic [7:0] lb = 0, sr = 0;
  logic [13:0] w;
  logic [15:0] s = 16'hc61c;
  int n_mismatch = 0, checks_done = 0;
  // clock, sequencer and memory
  always #5 clk = ~clk;
  pcs_sequencer pcs_sequencer_i (.CLK(clk), .RST(rst), .SHARED_RESET_PIN_N(pin_n), .INSTR_ADDR(a), .INSTR_WORD(w),
    .INSTR_OUT(), .INSTR_VALID(), .FLOW_OP(op), .FLOW_TARGET(tgt), .LOW_BYTE_DATA(lb), .STATUS_REG(sr),
    .IRQ_TAKE(irq), .INSTRUCTION_POINTER(ip), .STACK_LEVEL());
  pcs_mem pcs_mem_i (.addr(a), .word(w));
  // xorshift source
  function logic [10:0] rnd;
    s ^= s << 7;
    s ^= s >> 9;
    s ^= s << 8;
    return s[10:0];
  endfunction
  // compare and count
  task chk(input logic [10:0] v, e);
    checks_done++;
    if (v !== e)
    begin
      n_mismatch++;
      $display("MISMATCH ip exp %h seen %h", e, v);
    end
  endtask
  // flow op, then a flush slot whose op must be ignored
  task st(input pcs_op_e o, input logic i, input logic [10:0] t, e);
    op = o;
    irq = i;
    tgt = t;
    q.push_back(e);
    @(negedge clk) op = PCS_OP_TRAP;
    irq = 0;
    q.push_back(e + 11'h1);
    @(negedge clk);
  endtask
  // oldest note against the pointer after each edge
  always @(posedge clk)
    if (q.size() > 0)
      #1 chk(ip, q.pop_front());
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #2000 n_mismatch++;
    test_done;
  end
  // main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    q.push_back(0);
    @(negedge clk) rst = 0;
    q.push_back(1);
    @(negedge clk) r = rnd();
    st(PCS_OP_JUMP, 0, r, r);
    st(PCS_OP_CALL, 0, 11'h7ff, 11'h7ff);
    st(PCS_OP_TRAP, 0, 0, 1);
    st(PCS_OP_NEXT, 1, 0, 8);
    st(PCS_OP_RET, 0, 0, 2);
    st(PCS_OP_RET, 0, 0, 0);
    st(PCS_OP_RET, 0, 0, r + 11'h1);
    r = rnd();
    lb = r[7:0];
    sr = r[10:3];
    st(PCS_OP_LOW_WR, 0, 0, {sr[6], sr[5], 1'b0, lb});
    st(PCS_OP_SKIP, 0, 0, {sr[6], sr[5], 1'b0, lb} + 11'h2);
    $display("flow sequence done");
    pin_n = 0;
    q.push_back(0);
    @(negedge clk) pin_n = 1;
    op = PCS_OP_NEXT;
    q.push_back(1);
    q.push_back(2);
    repeat (2) @(negedge clk);
    $display("reset restart done");
    for (int k = 1; k < 8; k++)
      st(PCS_OP_CALL, 0, 11'(k * 40), 11'(k * 40));
    for (int k = 6; k > 0; k--)
      st(PCS_OP_RET, 0, 0, 11'(k * 40 + 1));
    $display("stack wrap done");
    test_done;
  end
endmodule
